// ---- rxs_cfg.svh ----
// Constants for the range extreme search unit
`ifndef RXS_CFG_SVH
`define RXS_CFG_SVH

// Control word fields and the result sign bit
`define RXS_IDX_BIT 14
`define RXS_SGN_BIT 15
`define RXS_SIGN_BIT 15

// Data area bases and sizes in the physical word space
`define RXS_IO_BASE 16'h0000
`define RXS_IO_SIZE 16'h0400
`define RXS_DM_BASE 16'h1000
`define RXS_DM_SIZE 16'h1800
`define RXS_EM_BASE 16'h3000
`define RXS_EM_SIZE 16'h1800
`define RXS_HR_BASE 16'h4800
`define RXS_HR_SIZE 16'h0064

// Result values
`define RXS_ZERO_WORD 16'h0000
`define RXS_OFS_ORIGIN 16'h0000

`endif

// ---- rxs_cmp.sv ----
// Strict ranking of a candidate word against the best so far
`timescale 1ns/1ns
`default_nettype none
module rxs_cmp
	import rxs_pkg::*;
(
	rxs_cmp_if.cmp cif // Comparison operands and verdict
);
	logic gt;
	logic lt;

	// Signed or unsigned ordering; ties never replace the best
	always_comb
	begin
		if (cif.sgn)
		begin
			gt = $signed(cif.cand) > $signed(cif.best);
			lt = $signed(cif.cand) < $signed(cif.best);
		end
		else
		begin
			gt = cif.cand > cif.best;
			lt = cif.cand < cif.best;
		end
		cif.take = cif.minm ? lt : gt;
	end
endmodule
`default_nettype wire

// ---- rxs_cmp_if.sv ----
// Candidate versus best comparison signals
`timescale 1ns/1ns
`default_nettype none
interface rxs_cmp_if;
	logic [15:0] cand;
	logic [15:0] best;
	logic sgn;
	logic minm;
	logic take;

	modport cmp (input cand, input best, input sgn, input minm, output take);
	modport user (output cand, output best, output sgn, output minm,
		input take);
endinterface
`default_nettype wire

// ---- rxs_mem.sv ----
// Word-addressed data memory model on the far side of the search unit
`timescale 1ns/1ns
`default_nettype none
module rxs_mem
(
	input wire logic core_clk, // Controller clock
	input wire logic rd_en, // Read request
	input wire logic [15:0] rd_addr, // Read address
	input wire logic wr_en, // Write strobe
	input wire logic [15:0] wr_data_en_unused, // Spare, not used
	input wire logic [15:0] wr_addr, // Write address
	input wire logic [15:0] wr_data, // Write data
	output logic [15:0] rd_data // Read data in the request cycle
);
	logic [15:0] words [0:65535];
	logic [15:0] junk_r = 16'h5A5A;

	// Junk that flips each cycle; writes land at the edge
	always @(posedge core_clk)
	begin
		junk_r <= ~junk_r;
		if (wr_en)
			words[wr_addr] <= wr_data;
	end

	// Same-cycle read answer; junk while no read is requested
	assign rd_data = rd_en ? words[rd_addr] : junk_r;
endmodule
`default_nettype wire

// ---- rxs_pkg.sv ----
// Types for the range extreme search unit
package rxs_pkg;

	// Data area selector
	typedef enum logic [1:0] {
		RXS_AREA_IO,
		RXS_AREA_DM,
		RXS_AREA_EM,
		RXS_AREA_HR
	} rxs_area_t;

	// Sequencer states
	typedef enum logic [1:0] {
		RXS_IDLE,
		RXS_SCAN,
		RXS_LOC
	} rxs_state_t;

	// Whole state of the search unit
	typedef struct packed {
		rxs_state_t st;
		logic busy;
		logic [9:0] cnt;
		logic [9:0] idx;
		logic [15:0] best;
		logic [15:0] best_loc;
		logic [15:0] pend_loc;
		logic [15:0] loc;
		logic have;
		logic sgn;
		logic minm;
		logic want;
		logic [15:0] dest;
		logic rd_en;
		logic [15:0] rd_addr;
		logic wr_en;
		logic [15:0] wr_addr;
		logic [15:0] wr_data;
		logic wval;
		logic done;
		logic err;
		logic zero;
		logic neg;
	} rxs_st_t;

endpackage

// ---- rxs_search.sv ----
// Range extreme search unit: maximum or minimum over a word range
// Functional notes
// - The word count is the three low BCD digits of the control word.
// - With the execution condition low nothing is searched or written.
// - Maximum mode reads every word of the range and writes the largest.
// - Minimum mode scans the same way and writes the smallest.
// - Control bit 14 adds a location write to the word after the result.
// - In the data memory area the location is the absolute word number.
// - In other areas the location is the offset from the first word.
// - Equal extremes report the lowest-addressed word.
// - Control bit 15 selects signed instead of unsigned comparison.
// - Signed mode ranks words with the top bit set as negative.
// - A count field that is not valid BCD or is zero raises the error.
// - A range whose first and last words differ in area is an error.
// - A bad indirect pointer or one past its area end is an error.
// - In maximum mode the zero flag shows a maximum of zero.
// - In minimum mode the zero flag shows a minimum of zero.
// - The negative flag copies bit 15 of the written result.
`timescale 1ns/1ns
`default_nettype none
`include "rxs_cfg.svh"
module rxs_search
	import rxs_pkg::*;
(
	input wire logic core_clk, // Controller clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic start, // Instruction issue pulse
	input wire logic exec_cond, // Execution condition
	input wire logic search_min, // High for minimum, low for maximum
	input wire logic [15:0] ctrl_word, // Control word
	input wire logic [1:0] range_area, // Area of the first word
	input wire logic [15:0] range_start_word, // BCD word number in area
	input wire logic ind_en, // First word given by indirect pointer
	input wire logic ind_em, // Pointer targets extended memory
	input wire logic [15:0] ind_ptr, // BCD indirect pointer
	input wire logic [15:0] dest_addr, // Physical destination address
	input wire logic [15:0] mem_rd_data, // Read data in the request cycle
	output logic mem_rd_en, // Memory read request
	output logic [15:0] mem_rd_addr, // Memory read address
	output logic mem_wr_en, // Memory write strobe
	output logic [15:0] mem_wr_addr, // Memory write address
	output logic [15:0] mem_wr_data, // Memory write data
	output logic busy, // Search in progress
	output logic done, // Completion pulse
	output logic error_flag, // Error result flag
	output logic zero_result_flag, // Result is zero
	output logic neg_flag // Result bit 15
);
	rxs_st_t s;
	rxs_st_t n;
	rxs_cmp_if cif ();
	rxs_area_t area;
	logic [15:0] word_bcd;
	logic [13:0] word_bin;
	logic [9:0] cnt_bin;
	logic [13:0] cnt_full;
	logic [15:0] base;
	logic [15:0] size;
	logic [15:0] last_w;
	logic [15:0] start_addr;
	logic [15:0] loc0;
	logic cnt_bad;
	logic ptr_bad;
	logic span_bad;
	logic any_err;
	logic upd;
	logic [15:0] nbest;
	logic [15:0] nloc;

	// True when every nibble is a decimal digit
	function automatic logic bcd_ok(input logic [15:0] v);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++)
			ok = ok & (v[i*4 +: 4] <= 4'h9);
		return ok;
	endfunction

	// Four BCD digits to binary
	function automatic logic [13:0] bcd2bin(input logic [15:0] v);
		return 14'({10'h000, v[15:12]} * 14'h03E8)
			+ 14'({10'h000, v[11:8]} * 14'h0064)
			+ 14'({10'h000, v[7:4]} * 14'h000A)
			+ {10'h000, v[3:0]};
	endfunction

	// Four-digit BCD increment
	function automatic logic [15:0] bcd_inc(input logic [15:0] v);
		logic [15:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			if (c)
			begin
				if (v[i*4 +: 4] == 4'h9)
					r[i*4 +: 4] = 4'h0;
				else
				begin
					r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction

	rxs_cmp u_cmp (
		.cif(cif)
	);

	// Operand decode and error checks at issue
	always_comb
	begin
		word_bcd = ind_en ? ind_ptr : range_start_word;
		if (ind_en)
			area = ind_em ? RXS_AREA_EM : RXS_AREA_DM;
		else
			area = rxs_area_t'(range_area);
		case (area)
			RXS_AREA_IO:
			begin
				base = `RXS_IO_BASE;
				size = `RXS_IO_SIZE;
			end
			RXS_AREA_DM:
			begin
				base = `RXS_DM_BASE;
				size = `RXS_DM_SIZE;
			end
			RXS_AREA_EM:
			begin
				base = `RXS_EM_BASE;
				size = `RXS_EM_SIZE;
			end
			default:
			begin
				base = `RXS_HR_BASE;
				size = `RXS_HR_SIZE;
			end
		endcase
		word_bin = bcd2bin(word_bcd);
		cnt_full = bcd2bin({4'h0, ctrl_word[11:0]});
		cnt_bin = cnt_full[9:0];
		cnt_bad = !bcd_ok({4'h0, ctrl_word[11:0]})
			|| (cnt_bin == 10'h000);
		ptr_bad = ind_en && (!bcd_ok(word_bcd)
			|| {2'h0, word_bin} >= size);
		last_w = {2'h0, word_bin} + {6'h00, cnt_bin} - 16'h0001;
		span_bad = !bcd_ok(word_bcd) || (last_w >= size);
		any_err = cnt_bad || ptr_bad || span_bad;
		start_addr = base + {2'h0, word_bin};
		// Absolute number in data memory, offset elsewhere
		loc0 = (area == RXS_AREA_DM) ? word_bcd
			: `RXS_OFS_ORIGIN;
	end

	// Comparison of the word returned this cycle
	always_comb
	begin
		cif.cand = mem_rd_data;
		cif.best = s.best;
		cif.sgn = s.sgn;
		cif.minm = s.minm;
		upd = s.rd_en && (!s.have || cif.take);
		nbest = upd ? mem_rd_data : s.best;
		nloc = upd ? s.pend_loc : s.best_loc;
	end

	// Next-state logic
	always_comb
	begin
		n = s;
		n.done = 1'b0;
		n.rd_en = 1'b0;
		n.wr_en = 1'b0;
		n.wval = 1'b0;
		case (s.st)
			RXS_IDLE:
			begin
				if (start && !exec_cond)
					n.done = 1'b1;
				else if (start && any_err)
				begin
					n.done = 1'b1;
					n.err = 1'b1;
					n.zero = 1'b0;
					n.neg = 1'b0;
				end
				else if (start)
				begin
					n.st = RXS_SCAN;
					n.cnt = cnt_bin;
					n.idx = 10'h001;
					n.rd_en = 1'b1;
					n.rd_addr = start_addr;
					n.pend_loc = loc0;
					n.loc = bcd_inc(loc0);
					n.have = 1'b0;
					n.sgn = ctrl_word[`RXS_SGN_BIT];
					n.minm = search_min;
					n.want = ctrl_word[`RXS_IDX_BIT];
					n.dest = dest_addr;
				end
			end
			RXS_SCAN:
			begin
				if (s.rd_en)
				begin
					n.best = nbest;
					n.best_loc = nloc;
					n.have = 1'b1;
				end
				if (s.idx != s.cnt)
				begin
					// Read start through start plus count minus one
					n.idx = s.idx + 10'h001;
					n.rd_en = 1'b1;
					n.rd_addr = s.rd_addr + 16'h0001;
					n.pend_loc = s.loc;
					n.loc = bcd_inc(s.loc);
				end
				else if (s.rd_en)
				begin
					n.wr_en = 1'b1;
					n.wr_addr = s.dest;
					n.wr_data = nbest;
					n.wval = 1'b1;
					n.err = 1'b0;
					n.zero = (nbest == `RXS_ZERO_WORD);
					n.neg = nbest[`RXS_SIGN_BIT];
					n.st = s.want ? RXS_LOC : RXS_IDLE;
					n.done = !s.want;
				end
			end
			RXS_LOC:
			begin
				n.wr_en = 1'b1;
				n.wr_addr = s.dest + 16'h0001;
				n.wr_data = s.best_loc;
				n.done = 1'b1;
				n.st = RXS_IDLE;
			end
			default:
				n.st = RXS_IDLE;
		endcase
		n.busy = (n.st != RXS_IDLE);
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			s <= '0;
		else
			s <= n;
	end

	// Outputs straight from the state register
	assign mem_rd_en = s.rd_en;
	assign mem_rd_addr = s.rd_addr;
	assign mem_wr_en = s.wr_en;
	assign mem_wr_addr = s.wr_addr;
	assign mem_wr_data = s.wr_data;
	assign busy = s.busy;
	assign done = s.done;
	assign error_flag = s.err;
	assign zero_result_flag = s.zero;
	assign neg_flag = s.neg;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_noexec_quiet: assert property (start && !busy && !exec_cond |=>
		done && !mem_wr_en && !mem_rd_en && !busy)
		else $error("search ran with execution condition low");
	a_noexec_flags: assert property (start && !busy && !exec_cond |=>
		$stable(error_flag) && $stable(zero_result_flag) && $stable(neg_flag))
		else $error("flags changed with execution condition low");
	a_count_error: assert property (start && !busy && exec_cond
		&& ctrl_word[11:0] == 12'h000 |=> done && error_flag && !busy)
		else $error("zero count not flagged as error");
	a_err_no_write: assert property (done && error_flag |->
		!mem_wr_en && !zero_result_flag && !neg_flag && !$past(mem_wr_en))
		else $error("write or extra flag with error");
	a_neg_follow: assert property (s.wval |->
		neg_flag == mem_wr_data[15] && mem_wr_addr == s.dest)
		else $error("negative flag does not match result");
	a_zero_follow: assert property (s.wval |->
		zero_result_flag == (mem_wr_data == 16'h0000) && !error_flag)
		else $error("zero flag does not match result");
	a_all_read: assert property (s.wval |-> s.idx == s.cnt
		&& $past(mem_rd_en))
		else $error("result written before range fully read");
	a_read_step: assert property (s.st == RXS_SCAN
		&& s.idx != s.cnt |=> mem_rd_en
		&& mem_rd_addr == $past(mem_rd_addr) + 16'h0001)
		else $error("range not read word by word");
	a_max_grows: assert property (s.st == RXS_SCAN && s.have
		&& !s.minm && !s.sgn |=> s.best >= $past(s.best))
		else $error("maximum decreased during scan");
	a_min_falls: assert property (s.st == RXS_SCAN && s.have
		&& s.minm && s.sgn |=> $signed(s.best) <= $signed($past(s.best)))
		else $error("signed minimum increased during scan");
	a_loc_write: assert property (s.wval && s.want |=>
		mem_wr_en && mem_wr_addr == $past(mem_wr_addr) + 16'h0001 && done)
		else $error("location not written after result");
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the range extreme search unit
`timescale 1ns/1ns
`default_nettype none
`include "rxs_cfg.svh"
module testbench;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic start = 1'b0;
	logic exec_cond = 1'b1;
	logic search_min = 1'b0;
	logic [15:0] ctrl_word = 16'h0000;
	logic [1:0] range_area = 2'h1;
	logic [15:0] range_start_word = 16'h0000;
	logic ind_en = 1'b0;
	logic ind_em = 1'b0;
	logic [15:0] ind_ptr = 16'h0000;
	logic [15:0] dest_addr = 16'h4800;
	logic [15:0] mem_rd_data, mem_rd_addr, mem_wr_addr, mem_wr_data;
	logic mem_rd_en, mem_wr_en, busy, done;
	logic error_flag, zero_result_flag, neg_flag;
	int fails = 0;
	int comparisons = 0;
	int writes = 0;
	int wr_base = 0;
	int lat = 0;
	logic busy_seen = 1'b0;

	rxs_search u_rxs_search (.core_clk, .rst_b, .start, .exec_cond,
		.search_min, .ctrl_word, .range_area, .range_start_word, .ind_en,
		.ind_em, .ind_ptr, .dest_addr, .mem_rd_data, .mem_rd_en,
		.mem_rd_addr, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .busy, .done,
		.error_flag, .zero_result_flag, .neg_flag);
	rxs_mem u_rxs_mem (.core_clk, .rd_en(mem_rd_en), .rd_addr(mem_rd_addr),
		.wr_en(mem_wr_en), .wr_data_en_unused(16'h0000),
		.wr_addr(mem_wr_addr), .wr_data(mem_wr_data), .rd_data(mem_rd_data));

	// Clock and write counter
	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		if (mem_wr_en === 1'b1)
			writes <= writes + 1;
	end

	task automatic close_out();
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] word(input logic [15:0] a);
		return u_rxs_mem.words[a];
	endfunction

	// Writes seen since the last issue
	function automatic logic [15:0] wr_count();
		return 16'(writes - wr_base);
	endfunction

	// Issue one search and wait for its completion pulse
	task automatic run(input logic mn, input logic [15:0] cw,
		input logic [1:0] ar, input logic [15:0] sw);
		int n;
		@(negedge core_clk);
		wr_base = writes;
		search_min = mn;
		ctrl_word = cw;
		range_area = ar;
		range_start_word = sw;
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		busy_seen = busy;
		n = 0;
		while (done !== 1'b1 && n < 1100)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n == 1100)
		begin
			fails++;
			close_out();
		end
		lat = n;
		// Let the write issued with done land in memory
		@(negedge core_clk);
	endtask

	// Max over data memory, tie, absolute location
	task automatic s_max_dm();
		u_rxs_mem.words[`RXS_DM_BASE + 16'h000A] = 16'h0005;
		u_rxs_mem.words[`RXS_DM_BASE + 16'h000B] = 16'h0009;
		u_rxs_mem.words[`RXS_DM_BASE + 16'h000C] = 16'h0009;
		run(1'b0, 16'h4003, 2'h1, 16'h0010);
		check(word(16'h4800), 16'h0009);
		check(word(16'h4801), 16'h0011);
		check(wr_count(), 16'h0002);
		check(16'(lat), 16'h0004);
		check(16'(busy_seen), 16'h0001);
		check(16'(neg_flag), 16'h0000);
	endtask

	// Signed and unsigned ranking over another area
	task automatic s_signs();
		logic [15:0] exp [4] = '{16'h8001, 16'h0003, 16'h7FFF, 16'h8001};
		u_rxs_mem.words[16'h0064] = 16'h0003;
		u_rxs_mem.words[16'h0065] = 16'h8001;
		u_rxs_mem.words[16'h0066] = 16'h7FFF;
		u_rxs_mem.words[16'h0067] = 16'h8001;
		u_rxs_mem.words[16'h4801] = 16'hBEEF;
		for (int i = 0; i < 4; i++)
		begin
			run(i[0], {i[1], 15'h0004}, 2'h0, 16'h0100);
			check(word(16'h4800), exp[i]);
			check(16'(neg_flag), 16'(exp[i][15]));
			check(word(16'h4801), 16'hBEEF);
		end
		run(1'b1, 16'hC004, 2'h0, 16'h0100);
		check(word(16'h4801), 16'h0001);
	endtask

	// Zero results and the one-word range
	task automatic s_zero();
		u_rxs_mem.words[`RXS_DM_BASE + 16'h0014] = 16'h0000;
		u_rxs_mem.words[`RXS_DM_BASE + 16'h0015] = 16'h0005;
		run(1'b0, 16'h0002, 2'h1, 16'h0020);
		check(16'(zero_result_flag), 16'h0000);
		run(1'b0, 16'h0001, 2'h1, 16'h0020);
		check(16'(zero_result_flag), 16'h0001);
		run(1'b1, 16'h0002, 2'h1, 16'h0020);
		check(16'(zero_result_flag), 16'h0001);
		check(word(16'h4800), 16'h0000);
	endtask

	// Execution condition low leaves everything alone
	task automatic s_noexec();
		exec_cond = 1'b0;
		run(1'b0, 16'h4002, 2'h1, 16'h0020);
		exec_cond = 1'b1;
		check(wr_count(), 16'h0000);
		check(16'(lat), 16'h0000);
		check(16'(zero_result_flag), 16'h0001);
	endtask

	// One faulty request: nothing written, only the error flag
	task automatic err_case(input logic [15:0] cw, input logic [15:0] sw,
		input logic ie, input logic [15:0] ptr);
		ind_en = ie;
		ind_ptr = ptr;
		run(1'b0, cw, 2'h0, sw);
		ind_en = 1'b0;
		check(16'(error_flag), 16'h0001);
		check(wr_count(), 16'h0000);
		check(16'(zero_result_flag), 16'h0000);
		check(16'(busy_seen), 16'h0000);
	endtask

	// Indirect pointer into extended memory, offset location
	task automatic s_indirect();
		u_rxs_mem.words[`RXS_EM_BASE + 16'h0002] = 16'h0007;
		u_rxs_mem.words[`RXS_EM_BASE + 16'h0003] = 16'h0100;
		ind_en = 1'b1;
		ind_em = 1'b1;
		ind_ptr = 16'h0002;
		run(1'b0, 16'h4002, 2'h0, 16'h0000);
		ind_en = 1'b0;
		ind_em = 1'b0;
		check(word(16'h4800), 16'h0100);
		check(word(16'h4801), 16'h0001);
		check(16'(error_flag), 16'h0000);
	endtask

	initial
	begin
		repeat (20) @(negedge core_clk);
		rst_b = 1'b1;
		s_max_dm();
		s_signs();
		s_zero();
		s_noexec();
		err_case(16'h000A, 16'h0000, 1'b0, 16'h0000);
		err_case(16'h0000, 16'h0000, 1'b0, 16'h0000);
		err_case(16'h0005, 16'h1020, 1'b0, 16'h0000);
		err_case(16'h0001, 16'h0000, 1'b1, 16'h00A0);
		err_case(16'h0001, 16'h0000, 1'b1, 16'h6144);
		s_indirect();
		s_max_dm();
		check(16'(error_flag), 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
